// ===== core/mcr_master_ctrl.v
// master control and configuration register bank with its steering outputs
`timescale 1ns/1ps
`include "mcr_regs.vh"
module mcr_master_ctrl (
  // clock and reset
  input wire clk_in,
  input wire rst_n_in,
  // serial port register access, already in this clock domain
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  output wire [7:0] reg_rdata_out,
  output wire reg_hit_out,
  // wake-up events from the clock and port blocks
  input wire wake_osc_fail_in,
  input wire wake_alarm_in,
  input wire wake_port_match_in,
  // clock sources, clk_pin_in and slow_osc_in pass a two-flop stage, clock_select_in a single flop
  input wire clk_pin_in,
  input wire slow_osc_in,
  input wire clock_select_in,
  output wire slow_clock_out,
  output wire system_clock_sel_out,
  output wire system_clock_override_out,
  // ram address path
  input wire [15:0] ram_addr_in,
  output wire [15:0] ram_addr_out,
  output wire ram_enable_out,
  // display and analog controls
  output wire display_drive_enable_out,
  output wire [1:0] bandgap_power_mode_out,
  output wire bandgap_low_power_out,
  output wire bandgap_tight_out,
  output wire charge_pump_enable_out,
  output wire display_supply_from_core_out,
  // low-power memory port mask view
  output wire [31:0] port_mask_out
);
  ////////////////////////////////////////////////////////////////////////////
  // address decode
  function is_lpmem;
    input [7:0] a;
    begin
      is_lpmem = (a >= `MCR_LPMEM_FIRST) && (a <= `MCR_LPMEM_LAST);
    end
  endfunction

  wire wr_control = reg_wr_in && (reg_addr_in == `MCR_CONTROL_ADDR);
  wire wr_config = reg_wr_in && (reg_addr_in == `MCR_CONFIG_ADDR);
  wire wr_lpmem = reg_wr_in && is_lpmem(reg_addr_in);
  wire [3:0] lp_index = reg_addr_in[3:0] - 4'h1;

  ////////////////////////////////////////////////////////////////////////////
  // control and configuration registers
  reg [7:0] control_ff;
  reg [7:0] config_ff;
  reg status_clear_ff;
  reg lpmem_clear_ff;
  wire [7:0] nxt_control = reg_wdata_in & `MCR_CONTROL_KEEP;
  wire [7:0] nxt_config = reg_wdata_in & `MCR_CONFIG_KEEP;

  // stored bits; action bits never stored
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      control_ff <= `MCR_CONTROL_RESET;
      config_ff <= `MCR_CONFIG_RESET;
    end else begin
      if (wr_control) begin
        control_ff <= nxt_control;
      end
      if (wr_config) begin
        config_ff <= nxt_config;
      end
    end
  end

  // one-cycle action pulses from a write of 1
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_clear_ff <= 1'b0;
      lpmem_clear_ff <= 1'b0;
    end else begin
      status_clear_ff <= wr_control & reg_wdata_in[`MCR_BIT_STATUS_CLEAR];
      lpmem_clear_ff <= wr_control & reg_wdata_in[`MCR_BIT_LPMEM_CLEAR];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wake-up status
  wire [2:0] wake_flags;
  mcr_wake_status u_wake (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .set_in({wake_osc_fail_in, wake_alarm_in, wake_port_match_in}),
    .clear_in(status_clear_ff),
    .flags_out(wake_flags)
  );

  ////////////////////////////////////////////////////////////////////////////
  // low-power memory
  reg [7:0] lpmem_ff [0:15];
  genvar g;
  generate
    for (g = 0; g < `MCR_LPMEM_COUNT; g = g + 1) begin : g_lpmem
      // clear pulse beats a same-cycle write
      always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          lpmem_ff[g] <= 8'h00;
        end else if (lpmem_clear_ff) begin
          lpmem_ff[g] <= 8'h00;
        end else if (wr_lpmem && (lp_index == g)) begin
          lpmem_ff[g] <= reg_wdata_in;
        end
      end
      // nibble top bits are the masks
      assign port_mask_out[2*g] = lpmem_ff[g][3];
      assign port_mask_out[2*g+1] = lpmem_ff[g][7];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // read path
  reg [7:0] rdata_ff;
  reg [7:0] nxt_rdata;
  always @* begin
    nxt_rdata = 8'h00;
    if (reg_addr_in == `MCR_CONTROL_ADDR) begin
      nxt_rdata = control_ff;
    end else if (reg_addr_in == `MCR_CONFIG_ADDR) begin
      nxt_rdata = config_ff;
    end else if (reg_addr_in == `MCR_STATUS_ADDR) begin
      nxt_rdata = {5'h00, wake_flags};
    end else if (is_lpmem(reg_addr_in)) begin
      nxt_rdata = lpmem_ff[lp_index];
    end
  end
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd_in) begin
      rdata_ff <= nxt_rdata;
    end
  end
  assign reg_rdata_out = rdata_ff;
  assign reg_hit_out = (reg_addr_in == `MCR_CONTROL_ADDR) ||
    (reg_addr_in == `MCR_CONFIG_ADDR) || (reg_addr_in == `MCR_STATUS_ADDR) ||
    is_lpmem(reg_addr_in);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  reg [1:0] pin_meta_ff;
  reg [1:0] pin_sync_ff;
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_meta_ff <= 2'h0;
      pin_sync_ff <= 2'h0;
    end else begin
      pin_meta_ff <= {clk_pin_in, slow_osc_in};
      pin_sync_ff <= pin_meta_ff;
    end
  end
  wire clk_pin_s = pin_sync_ff[1];
  wire slow_osc_s = pin_sync_ff[0];

  ////////////////////////////////////////////////////////////////////////////
  // clock steering
  wire osc_bypass = control_ff[`MCR_BIT_OSC_BYPASS];
  wire osc_gated = control_ff[`MCR_BIT_OSC_OUT_DIS];
  wire clk_override = control_ff[`MCR_BIT_CLK_OVERRIDE];
  reg slow_clock_ff;
  reg sysclk_sel_ff;
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      slow_clock_ff <= 1'b0;
      sysclk_sel_ff <= 1'b0;
    end else begin
      // bypass picks the pin, else the gated oscillator
      slow_clock_ff <= osc_bypass ? clk_pin_s : (slow_osc_s & ~osc_gated);
      // override forces the pin as system clock source
      sysclk_sel_ff <= clk_override ? clk_pin_s : clock_select_in;
    end
  end
  assign slow_clock_out = slow_clock_ff;
  assign system_clock_sel_out = sysclk_sel_ff;
  assign system_clock_override_out = clk_override;

  ////////////////////////////////////////////////////////////////////////////
  // ram controls
  reg [15:0] ram_addr_ff;
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ram_addr_ff <= 16'h0000;
    end else begin
      ram_addr_ff <= {ram_addr_in[15:8],
        ram_addr_in[7:0] ^ {8{control_ff[`MCR_BIT_ADDR_INVERT]}}};
    end
  end
  assign ram_addr_out = ram_addr_ff;
  assign ram_enable_out = ~control_ff[`MCR_BIT_RAM_DISABLE];

  ////////////////////////////////////////////////////////////////////////////
  // display and analog controls
  wire [1:0] bg_mode = config_ff[`MCR_BG_HI:`MCR_BG_LO];
  assign display_drive_enable_out = control_ff[`MCR_BIT_DISPLAY_EN];
  assign bandgap_power_mode_out = bg_mode;
  assign bandgap_low_power_out = (bg_mode == `MCR_BG_LOOSE) || (bg_mode == `MCR_BG_TIGHT);
  assign bandgap_tight_out = (bg_mode == `MCR_BG_TIGHT);
  assign charge_pump_enable_out = ~config_ff[`MCR_BIT_PUMP_BYPASS];
  assign display_supply_from_core_out = config_ff[`MCR_BIT_PUMP_BYPASS];
endmodule

// ===== core/mcr_regs.vh
// register offsets, field positions and reset values of the master control registers
`ifndef MCR_REGS_VH
`define MCR_REGS_VH
`define MCR_ADDR_W 8
`define MCR_DATA_W 8
`define MCR_CONTROL_ADDR 8'hA0
`define MCR_CONFIG_ADDR 8'hA1
`define MCR_STATUS_ADDR 8'h42
`define MCR_LPMEM_FIRST 8'h81
`define MCR_LPMEM_LAST 8'h90
`define MCR_LPMEM_COUNT 16
`define MCR_CONTROL_RESET 8'h00
`define MCR_CONFIG_RESET 8'h00
`define MCR_BIT_OSC_BYPASS 7
`define MCR_BIT_STATUS_CLEAR 6
`define MCR_BIT_ADDR_INVERT 5
`define MCR_BIT_OSC_OUT_DIS 4
`define MCR_BIT_RAM_DISABLE 3
`define MCR_BIT_CLK_OVERRIDE 2
`define MCR_BIT_LPMEM_CLEAR 1
`define MCR_BIT_DISPLAY_EN 0
`define MCR_BG_HI 7
`define MCR_BG_LO 6
`define MCR_BIT_PUMP_BYPASS 0
`define MCR_CONTROL_KEEP 8'hBD
`define MCR_CONFIG_KEEP 8'hC1
`define MCR_BG_NORMAL 2'h0
`define MCR_BG_RESERVED 2'h1
`define MCR_BG_LOOSE 2'h2
`define MCR_BG_TIGHT 2'h3
`define MCR_STATUS_W 3
`endif

// ===== core/mcr_wake_status.v
// wake-up status flags with a clear that loses to a new event
`timescale 1ns/1ps
module mcr_wake_status (
  // clock and reset
  input wire clk_in,
  input wire rst_n_in,
  // events and clear
  input wire [2:0] set_in,
  input wire clear_in,
  // flags
  output wire [2:0] flags_out
);
  reg [2:0] flags_ff;
  wire [2:0] nxt_flags;
  genvar i;
  // each flag: set wins over clear
  generate
    for (i = 0; i < 3; i = i + 1) begin : g_flag
      assign nxt_flags[i] = set_in[i] | (flags_ff[i] & ~clear_in);
    end
  endgenerate
  // flag storage
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flags_ff <= 3'h0;
    end else begin
      flags_ff <= nxt_flags;
    end
  end
  assign flags_out = flags_ff;
endmodule

// ===== tb/mcr_master_ctrl_monitor.sv
// concurrent checks on the master control register bank ports
`timescale 1ns/1ps
module mcr_master_ctrl_monitor (
  // clock, reset and register access
  input wire clk_in, rst_n_in, reg_wr_in, reg_rd_in,
  input wire [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out,
  // clock steering
  input wire clock_select_in, system_clock_sel_out, system_clock_override_out,
  // steering and analog controls
  input wire ram_enable_out, display_drive_enable_out, bandgap_low_power_out,
  input wire bandgap_tight_out, charge_pump_enable_out, display_supply_from_core_out,
  input wire [1:0] bandgap_power_mode_out,
  input wire [15:0] ram_addr_in, ram_addr_out,
  input wire [31:0] port_mask_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // writes to the control and configuration bytes
  wire wc = reg_wr_in && reg_addr_in == 8'hA0;
  wire wf = reg_wr_in && reg_addr_in == 8'hA1;
  a_ram_en_follow: assert property (wc |=> ram_enable_out == !$past(reg_wdata_in[3]))
    else $error("ram enable does not follow control bit 3");
  a_disp_en_follow: assert property (wc |=> display_drive_enable_out == $past(reg_wdata_in[0]))
    else $error("display enable does not follow control bit 0");
  a_ovr_follow: assert property (wc |=> system_clock_override_out == $past(reg_wdata_in[2]))
    else $error("clock override does not follow control bit 2");
  a_sys_clk_follow: assert property (!system_clock_override_out ##1 !system_clock_override_out
    |-> system_clock_sel_out == $past(clock_select_in)) else $error("system clock choice wrong");
  a_bg_mode_follow: assert property (wf |=> bandgap_power_mode_out == $past(reg_wdata_in[7:6]))
    else $error("bandgap mode does not follow config bits 7:6");
  a_bg_decode: assert property (bandgap_low_power_out == bandgap_power_mode_out[1] &&
    bandgap_tight_out == (bandgap_power_mode_out == 2'h3)) else $error("bandgap decode wrong");
  a_pump_bypass: assert property (wf |=> display_supply_from_core_out == $past(reg_wdata_in[0])
    && charge_pump_enable_out == !$past(reg_wdata_in[0])) else $error("pump bypass wrong");
  a_mask_clear: assert property (wc && reg_wdata_in[1] |-> ##3 port_mask_out == 32'h0)
    else $error("memory clear left mask bits set");
  a_addr_high_pass: assert property (ram_addr_out[15:8] == $past(ram_addr_in[15:8]))
    else $error("ram address high byte altered");
  a_status_unused: assert property (reg_rd_in && reg_addr_in == 8'h42 |=>
    reg_rdata_out[7:3] == 5'h00) else $error("status upper bits not zero");
  c_control_write: cover property (wc);
  c_mask_clear: cover property (wc && reg_wdata_in[1]);
  c_bg_tight: cover property (bandgap_tight_out);
endmodule
bind mcr_master_ctrl mcr_master_ctrl_monitor mcr_master_ctrl_monitor_inst (.*);

// ===== tb/tb.sv
// self-checking bench for the master control register bank
`timescale 1ns/1ps
module tb;
  reg clk_in = 0, rst_n_in = 0, reg_wr_in = 0, reg_rd_in = 0;
  reg [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00;
  reg wf = 0, wa = 0, wp = 0, pin = 0, osc = 0, csel = 0;
  reg [15:0] ram_addr_in = 16'h0000;
  wire [7:0] rdata;
  wire hit, slow, ssel, sovr, ram_en, disp, bg_lo, bg_t, pump, core;
  wire [1:0] bg;
  wire [15:0] ram_addr_out;
  wire [31:0] mask;
  integer n_fail = 0, comparisons = 0, cyc = 0, i;
  mcr_master_ctrl mcr_master_ctrl_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(rdata), .reg_hit_out(hit),
    .wake_osc_fail_in(wf), .wake_alarm_in(wa), .wake_port_match_in(wp),
    .clk_pin_in(pin), .slow_osc_in(osc), .clock_select_in(csel), .slow_clock_out(slow),
    .system_clock_sel_out(ssel), .system_clock_override_out(sovr),
    .ram_addr_in(ram_addr_in), .ram_addr_out(ram_addr_out), .ram_enable_out(ram_en),
    .display_drive_enable_out(disp), .bandgap_power_mode_out(bg),
    .bandgap_low_power_out(bg_lo), .bandgap_tight_out(bg_t),
    .charge_pump_enable_out(pump), .display_supply_from_core_out(core), .port_mask_out(mask));
  // 100 MHz clock
  initial forever #5 clk_in = ~clk_in;
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task tick(input integer n);
    begin
      repeat (n) @(posedge clk_in);
      #1;
    end
  endtask
  // one write strobe, released after the taking edge
  task wr(input [7:0] a, input [7:0] d);
    begin
      tick(1);
      reg_wr_in = 1;
      reg_addr_in = a;
      reg_wdata_in = d;
      tick(1);
      reg_wr_in = 0;
    end
  endtask
  // one read strobe, data judged after the answering edge
  task rd(input [7:0] a, input [7:0] e, input string nm);
    begin
      tick(1);
      reg_rd_in = 1;
      reg_addr_in = a;
      tick(1);
      reg_rd_in = 0;
      chk(nm, e, rdata);
    end
  endtask
  task test_done;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task t_reset;
    begin
      rd(8'hA0, 8'h00, "control");
      chk("hit", 1, hit);
      rd(8'hA1, 8'h00, "config");
      chk("ram_en", 1, ram_en);
      chk("pump", 1, pump);
      rd(8'h55, 8'h00, "unmapped");
      chk("hit", 0, hit);
    end
  endtask
  task t_control;
    begin
      wr(8'hA0, 8'hFF);
      chk("disp", 1, disp);
      chk("ram_en", 0, ram_en);
      chk("ovr", 1, sovr);
      rd(8'hA0, 8'hBD, "control");
      wr(8'hA0, 8'h00);
      chk("disp", 0, disp);
    end
  endtask
  task t_config;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        wr(8'hA1, {i[1:0], 5'h00, i[0]});
        chk("bg", i, bg);
        chk("bg_lo", i >= 2, bg_lo);
        chk("bg_t", i == 3, bg_t);
        chk("core", i[0], core);
        chk("pump", !i[0], pump);
        rd(8'hA1, {i[1:0], 5'h00, i[0]}, "config");
      end
    end
  endtask
  task t_invert;
    begin
      wr(8'hA0, 8'h20);
      ram_addr_in = 16'h0400;
      tick(1);
      chk("ram_addr", 16'h04FF, ram_addr_out);
      wr(8'hA0, 8'h00);
      tick(1);
      chk("ram_addr", 16'h0400, ram_addr_out);
    end
  endtask
  // wake flags are read only and cleared by the status clear bit
  task t_status;
    begin
      {wf, wa, wp} = 3'b110;
      tick(1);
      {wf, wa, wp} = 3'b000;
      rd(8'h42, 8'h06, "status");
      wr(8'h42, 8'h00);
      rd(8'h42, 8'h06, "status");
      wr(8'hA0, 8'h40);
      tick(2);
      rd(8'h42, 8'h00, "status");
    end
  endtask
  task t_mem;
    begin
      wr(8'h81, 8'h88);
      wr(8'h90, 8'h08);
      chk("mask", 32'h40000003, mask);
      rd(8'h90, 8'h08, "mem");
      wr(8'hA0, 8'h02);
      tick(2);
      chk("mask", 0, mask);
      rd(8'h81, 8'h00, "mem");
    end
  endtask
  task t_clocks;
    begin
      pin = 1;
      wr(8'hA0, 8'h84);
      tick(4);
      chk("slow", 1, slow);
      chk("sys_sel", 1, ssel);
      pin = 0;
      osc = 1;
      csel = 1;
      wr(8'hA0, 8'h10);
      tick(4);
      chk("slow", 0, slow);
      chk("sys_sel", 1, ssel);
      wr(8'hA0, 8'h00);
      tick(4);
      chk("slow", 1, slow);
    end
  endtask
  // cycle ceiling against hangs
  always @(posedge clk_in) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      n_fail = n_fail + 1;
      test_done;
    end
  end
  initial begin
    tick(20);
    rst_n_in = 1;
    t_reset;
    t_control;
    t_config;
    t_invert;
    t_status;
    t_mem;
    t_clocks;
    test_done;
  end
endmodule
